// ### rtl/lig_defines.vh
/*
 Constants for the link interrupt and GPIO control block: register offsets,
 field positions, reset values and mode codes.
 Assumes it is included by bare name from files under rtl/.
*/
// What this block does
// R01 - Active-low interrupt output from enabled status bits
// R02 - Controller sets enable bits 5 and 0
// R03 - Low remote interrupt input pulls output low
// R04 - Reading status clears pending, releases output
// R05 - Controller reads status after seeing output low
// R06 - Remote interrupt re-arms on next falling edge
// R07 - Mirror output follows remote interrupt level
// R08 - Mirror held high while link is down
// R09 - Each link GPIO forward or back channel
// R10 - Port select bits steer configuration writes
// R11 - Second-port GPIOs need two-lane mode
// R12 - GPIO3 mode in low nibble of 0x0F
// R13 - GPIO2 mode in high nibble of 0x0E
// R14 - GPIO1 mode in low nibble of 0x0E
// R15 - GPIO0 mode in low nibble of 0x0D
// R16 - Remote deserializer picks back-channel sampling mode
// R17 - Samples per frame: 1, 6, 10, 15
// R18 - Register-only GPIOs driven or read via registers
// R19 - Register GPIO mode overrides shared I2S input
// R20 - Register GPIOs reachable locally and remotely
// R21 - Register GPIO state never sent over link
// R22 - Both selected: read second port, write both
// R23 - Synchronise remote interrupt before edge detect
`ifndef LIG_DEFINES_VH
`define LIG_DEFINES_VH

`define LIG_A_GPIO0 8'h0D
`define LIG_A_GPIO12 8'h0E
`define LIG_A_GPIO3 8'h0F
`define LIG_A_RGPIO56 8'h10
`define LIG_A_RGPIO78 8'h11
`define LIG_A_RGPIO_IN 8'h1D
`define LIG_A_PORT_SEL 8'h1E
`define LIG_A_INT_CTL 8'hC6
`define LIG_A_INT_STS 8'hC7

`define LIG_CFG_FWD 4'h3
`define LIG_CFG_BC 4'h5

`define LIG_SEL_P0 0
`define LIG_SEL_P1 1
`define LIG_SEL_RST 8'h01

`define LIG_INT_GLOBAL 0
`define LIG_INT_REMOTE 5
`define LIG_INT_LOC_LO 1
`define LIG_INT_LOC_HI 4

`define LIG_RG_EN 0
`define LIG_RG_IN 1
`define LIG_RG_VAL 3

`define LIG_BC_NORMAL 3'h0
`define LIG_BC_FAST4 3'h3
`define LIG_BC_FAST2 3'h2
`define LIG_BC_FAST1 3'h1
`define LIG_BC_N_NORMAL 4'h1
`define LIG_BC_N_FAST4 4'h6
`define LIG_BC_N_FAST2 4'hA
`define LIG_BC_N_FAST1 4'hF
`define LIG_BC_M_ALL 4'hF
`define LIG_BC_M_TWO 4'h3
`define LIG_BC_M_ONE 4'h1

`endif

// ### rtl/lig_bc_sampler.v
/*
 Back-channel GPIO sampler for one downstream port: takes link samples,
 limits them per frame by the sampling mode and holds the pin values.
 Assumes frame and sample strobes come from link logic on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lig_defines.vh"
module lig_bc_sampler #(
   parameter WIDTH = 4
) (
   input wire sys_clk,
   input wire rst,
   input wire ce,
   input wire frame_start,
   input wire sample_valid,
   input wire [WIDTH-1:0] sample,
   input wire [2:0] rate_mode,
   output reg [WIDTH-1:0] held_r
);
   reg [3:0] count_r;
   reg [3:0] limit;
   reg [WIDTH-1:0] mask;
   wire [3:0] count_eff;
   wire accept;

   // The mode is set by the remote deserializer; this end only follows it.
   always @* begin // R16
      case (rate_mode)
         `LIG_BC_NORMAL: begin
            limit = `LIG_BC_N_NORMAL;
            mask = `LIG_BC_M_ALL;
         end
         `LIG_BC_FAST4: begin
            limit = `LIG_BC_N_FAST4;
            mask = `LIG_BC_M_ALL;
         end
         `LIG_BC_FAST2: begin
            limit = `LIG_BC_N_FAST2;
            mask = `LIG_BC_M_TWO;
         end
         `LIG_BC_FAST1: begin
            limit = `LIG_BC_N_FAST1;
            mask = `LIG_BC_M_ONE;
         end
         default: begin
            limit = `LIG_BC_N_NORMAL;
            mask = `LIG_BC_M_ALL;
         end
      endcase
   end

   assign count_eff = frame_start ? 4'h0 : count_r;
   assign accept = sample_valid && (count_eff < limit); // R17

   always @(posedge sys_clk) begin
      if (rst) begin
         count_r <= 4'h0;
         held_r <= {WIDTH{1'b0}};
      end else if (ce) begin
         count_r <= accept ? count_eff + 4'h1 : count_eff;
         if (accept) begin
            held_r <= (held_r & ~mask) | (sample & mask); // R17
         end
      end
   end
endmodule // lig_bc_sampler
`default_nettype wire

// ### rtl/lig_link_int_gpio.v
/*
 Interrupt and GPIO control of the serializer: interrupt output, remote
 interrupt mirror, link GPIO configuration for two ports, register GPIOs.
 Assumes link logic on sys_clk delivers back-channel samples, the remote
 interrupt level and link status; pins arrive asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lig_defines.vh"
module lig_link_int_gpio #(
   parameter NGPIO = 4,
   parameter NLOC = 4
) (
   input wire sys_clk,
   input wire rst,
   input wire ce,
   input wire loc_wr,
   input wire loc_rd,
   input wire [7:0] loc_addr,
   input wire [7:0] loc_wdata,
   output reg [7:0] loc_rdata_r,
   output reg loc_rvalid_r,
   input wire rem_wr,
   input wire rem_rd,
   input wire [7:0] rem_addr,
   input wire [7:0] rem_wdata,
   output reg [7:0] rem_rdata_r,
   output reg rem_ack_r,
   input wire link_up,
   input wire two_lane,
   input wire remote_interrupt_in_n,
   input wire [NLOC-1:0] local_int_evt,
   output reg interrupt_out_n,
   output reg remote_interrupt_mirror,
   input wire [2:0] backchannel_gpio_rate_mode,
   input wire bc_frame_start,
   input wire bc_valid_p0,
   input wire [NGPIO-1:0] bc_gpio_p0,
   input wire bc_valid_p1,
   input wire [NGPIO-1:0] bc_gpio_p1,
   output reg [NGPIO-1:0] fwd_gpio_p0_r,
   output reg [NGPIO-1:0] fwd_gpio_p1_r,
   input wire [NGPIO-1:0] gpio_in,
   output reg [NGPIO-1:0] gpio_out_r,
   output reg [NGPIO-1:0] gpio_oe_r,
   input wire [NGPIO-1:0] d_gpio_in,
   output reg [NGPIO-1:0] d_gpio_out_r,
   output reg [NGPIO-1:0] d_gpio_oe_r,
   input wire [3:0] rgpio_in,
   output reg [3:0] rgpio_out_r,
   output reg [3:0] rgpio_oe_r,
   output reg [3:0] i2s_data_r
);
   // Configuration nibble decode shared by both ports and all pins.
   function is_fwd;
      input [3:0] nib;
      begin
         is_fwd = (nib == `LIG_CFG_FWD);
      end
   endfunction

   function is_bc;
      input [3:0] nib;
      begin
         is_bc = (nib == `LIG_CFG_BC);
      end
   endfunction

   reg [7:0] gpio0_config_r [0:1];
   reg [7:0] gpio1_gpio2_config_r [0:1];
   reg [7:0] gpio3_config_r [0:1];
   reg [7:0] link_port_select_r;
   reg [7:0] rgpio56_config_r;
   reg [7:0] rgpio78_config_r;
   reg [7:0] int_ctl_r;
   reg [7:0] int_sts_r;
   reg [1:0] rint_sync_r;
   reg rint_prev_r;
   reg [NGPIO-1:0] gpio_s1_r;
   reg [NGPIO-1:0] gpio_s2_r;
   reg [NGPIO-1:0] dgpio_s1_r;
   reg [NGPIO-1:0] dgpio_s2_r;
   reg [3:0] rgpio_s1_r;
   reg [3:0] rgpio_s2_r;
   reg [7:0] rd_mux;
   reg [7:0] int_sts_nxt;
   reg [15:0] rgpio_cfg;

   wire acc_wr;
   wire acc_rd;
   wire [7:0] acc_addr;
   wire [7:0] acc_wdata;
   wire rem_go;
   wire rd_port;
   wire rint_fall;
   wire [NLOC-1:0] loc_en;
   wire [NGPIO-1:0] bc_held_p0;
   wire [NGPIO-1:0] bc_held_p1;
   wire [NGPIO-1:0] bc_held [0:1];
   wire [NGPIO-1:0] fwd_sel [0:1];
   wire [NGPIO-1:0] bc_sel [0:1];

   // Local access wins a shared cycle; the remote one is acknowledged only
   // when it is actually served, so the remote end retries otherwise.
   assign rem_go = (rem_wr || rem_rd) && !(loc_wr || loc_rd); // R20
   assign acc_wr = loc_wr || (rem_go && rem_wr);
   assign acc_rd = loc_rd || (rem_go && rem_rd);
   assign acc_addr = (loc_wr || loc_rd) ? loc_addr : rem_addr;
   assign acc_wdata = (loc_wr || loc_rd) ? loc_wdata : rem_wdata;

   // With both select bits set the second port is read back.
   assign rd_port = link_port_select_r[`LIG_SEL_P1]; // R22

   always @* begin
      rgpio_cfg = {rgpio78_config_r, rgpio56_config_r};
   end

   always @* begin
      case (acc_addr)
         `LIG_A_GPIO0: rd_mux = gpio0_config_r[rd_port];
         `LIG_A_GPIO12: rd_mux = gpio1_gpio2_config_r[rd_port];
         `LIG_A_GPIO3: rd_mux = gpio3_config_r[rd_port];
         `LIG_A_RGPIO56: rd_mux = rgpio56_config_r;
         `LIG_A_RGPIO78: rd_mux = rgpio78_config_r;
         `LIG_A_RGPIO_IN: rd_mux = {4'h0, rgpio_s2_r}; // R18
         `LIG_A_PORT_SEL: rd_mux = link_port_select_r;
         `LIG_A_INT_CTL: rd_mux = int_ctl_r;
         `LIG_A_INT_STS: rd_mux = int_sts_r;
         default: rd_mux = 8'h00;
      endcase
   end

   // R23: the remote level passes two flops before the edge detector.
   assign rint_fall = rint_prev_r && !rint_sync_r[1]; // R06
   assign loc_en = int_ctl_r[`LIG_INT_LOC_HI:`LIG_INT_LOC_LO];

   // Events set status bits; a set in the cycle of the clearing read wins.
   always @* begin
      int_sts_nxt = int_sts_r;
      if (acc_rd && (acc_addr == `LIG_A_INT_STS)) begin
         int_sts_nxt = 8'h00; // R04
      end
      if (rint_fall && int_ctl_r[`LIG_INT_REMOTE]) begin
         int_sts_nxt[`LIG_INT_REMOTE] = 1'b1; // R03
      end
      int_sts_nxt[`LIG_INT_LOC_HI:`LIG_INT_LOC_LO] =
         int_sts_nxt[`LIG_INT_LOC_HI:`LIG_INT_LOC_LO] |
         (local_int_evt & loc_en);
      int_sts_nxt[`LIG_INT_GLOBAL] =
         |int_sts_nxt[`LIG_INT_REMOTE:`LIG_INT_LOC_LO];
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         rint_sync_r <= 2'b11;
         rint_prev_r <= 1'b1;
         gpio_s1_r <= {NGPIO{1'b0}};
         gpio_s2_r <= {NGPIO{1'b0}};
         dgpio_s1_r <= {NGPIO{1'b0}};
         dgpio_s2_r <= {NGPIO{1'b0}};
         rgpio_s1_r <= 4'h0;
         rgpio_s2_r <= 4'h0;
      end else if (ce) begin
         rint_sync_r <= {rint_sync_r[0], remote_interrupt_in_n}; // R23
         rint_prev_r <= rint_sync_r[1];
         gpio_s1_r <= gpio_in;
         gpio_s2_r <= gpio_s1_r;
         dgpio_s1_r <= d_gpio_in;
         dgpio_s2_r <= dgpio_s1_r;
         rgpio_s1_r <= rgpio_in;
         rgpio_s2_r <= rgpio_s1_r;
      end
   end

   // Register file: duplicated link GPIO banks and shared registers.
   genvar p;
   generate
      for (p = 0; p < 2; p = p + 1) begin : g_bank
         always @(posedge sys_clk) begin
            if (rst) begin
               gpio0_config_r[p] <= 8'h00;
               gpio1_gpio2_config_r[p] <= 8'h00;
               gpio3_config_r[p] <= 8'h00;
            end else if (ce && acc_wr && link_port_select_r[p]) begin // R10
               if (acc_addr == `LIG_A_GPIO0) begin
                  gpio0_config_r[p] <= acc_wdata; // R22
               end
               if (acc_addr == `LIG_A_GPIO12) begin
                  gpio1_gpio2_config_r[p] <= acc_wdata;
               end
               if (acc_addr == `LIG_A_GPIO3) begin
                  gpio3_config_r[p] <= acc_wdata;
               end
            end
         end
         assign fwd_sel[p] = {is_fwd(gpio3_config_r[p][3:0]), // R12
            is_fwd(gpio1_gpio2_config_r[p][7:4]), // R13
            is_fwd(gpio1_gpio2_config_r[p][3:0]), // R14
            is_fwd(gpio0_config_r[p][3:0])}; // R15
         assign bc_sel[p] = {is_bc(gpio3_config_r[p][3:0]),
            is_bc(gpio1_gpio2_config_r[p][7:4]),
            is_bc(gpio1_gpio2_config_r[p][3:0]),
            is_bc(gpio0_config_r[p][3:0])}; // R09
      end
   endgenerate

   always @(posedge sys_clk) begin
      if (rst) begin
         link_port_select_r <= `LIG_SEL_RST;
         rgpio56_config_r <= 8'h00;
         rgpio78_config_r <= 8'h00;
         int_ctl_r <= 8'h00;
         int_sts_r <= 8'h00;
         loc_rdata_r <= 8'h00;
         loc_rvalid_r <= 1'b0;
         rem_rdata_r <= 8'h00;
         rem_ack_r <= 1'b0;
      end else if (ce) begin
         int_sts_r <= int_sts_nxt;
         loc_rvalid_r <= loc_rd;
         rem_ack_r <= rem_go;
         if (loc_rd) begin
            loc_rdata_r <= rd_mux;
         end
         if (rem_go && rem_rd) begin
            rem_rdata_r <= rd_mux; // R20
         end
         if (acc_wr) begin
            case (acc_addr)
               `LIG_A_PORT_SEL: link_port_select_r <= acc_wdata;
               `LIG_A_RGPIO56: rgpio56_config_r <= acc_wdata;
               `LIG_A_RGPIO78: rgpio78_config_r <= acc_wdata;
               `LIG_A_INT_CTL: int_ctl_r <= acc_wdata;
               default: ;
            endcase
         end
      end
   end

   // Back-channel samples for each port, held between updates.
   lig_bc_sampler #(.WIDTH(NGPIO)) u_bc_p0 (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .frame_start(bc_frame_start),
      .sample_valid(bc_valid_p0),
      .sample(bc_gpio_p0),
      .rate_mode(backchannel_gpio_rate_mode),
      .held_r(bc_held_p0)
   );

   lig_bc_sampler #(.WIDTH(NGPIO)) u_bc_p1 (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .frame_start(bc_frame_start),
      .sample_valid(bc_valid_p1 && two_lane),
      .sample(bc_gpio_p1),
      .rate_mode(backchannel_gpio_rate_mode),
      .held_r(bc_held_p1)
   );

   assign bc_held[0] = bc_held_p0;
   assign bc_held[1] = bc_held_p1;

   // Pin and link outputs, all registered.
   always @(posedge sys_clk) begin
      if (rst) begin
         interrupt_out_n <= 1'b1;
         remote_interrupt_mirror <= 1'b1;
         fwd_gpio_p0_r <= {NGPIO{1'b0}};
         fwd_gpio_p1_r <= {NGPIO{1'b0}};
         gpio_out_r <= {NGPIO{1'b0}};
         gpio_oe_r <= {NGPIO{1'b0}};
         d_gpio_out_r <= {NGPIO{1'b0}};
         d_gpio_oe_r <= {NGPIO{1'b0}};
      end else if (ce) begin
         interrupt_out_n <= !(int_ctl_r[`LIG_INT_GLOBAL] &&
            int_sts_nxt[`LIG_INT_GLOBAL]); // R01
         remote_interrupt_mirror <= link_up ? rint_sync_r[1] : 1'b1; // R07 R08
         fwd_gpio_p0_r <= gpio_s2_r & fwd_sel[0]; // R09
         fwd_gpio_p1_r <= two_lane ? (dgpio_s2_r & fwd_sel[1]) :
            {NGPIO{1'b0}}; // R11
         gpio_out_r <= bc_held[0] & bc_sel[0];
         gpio_oe_r <= bc_sel[0];
         d_gpio_out_r <= bc_held[1] & bc_sel[1];
         d_gpio_oe_r <= two_lane ? bc_sel[1] : {NGPIO{1'b0}}; // R11
      end
   end

   // Register GPIOs: local pins set by local or remote writes, nothing of them goes onto the link.
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_rgpio
         wire en = rgpio_cfg[4*g + `LIG_RG_EN];
         wire dir_in = rgpio_cfg[4*g + `LIG_RG_IN];
         wire val = rgpio_cfg[4*g + `LIG_RG_VAL];
         always @(posedge sys_clk) begin
            if (rst) begin
               rgpio_out_r[g] <= 1'b0;
               rgpio_oe_r[g] <= 1'b0;
               i2s_data_r[g] <= 1'b0;
            end else if (ce) begin
               rgpio_out_r[g] <= en && !dir_in && val; // R18 R21
               rgpio_oe_r[g] <= en && !dir_in;
               i2s_data_r[g] <= en ? 1'b0 : rgpio_s2_r[g]; // R19
            end
         end
      end
   endgenerate
endmodule // lig_link_int_gpio
`default_nettype wire

// ### tb/lig_link_int_gpio_sva.sv
/* Port checker for the link interrupt and GPIO block.
   Assumes binding to lig_link_int_gpio, clocked by sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module lig_link_int_gpio_chk (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic loc_wr,
   input wire logic loc_rd,
   input wire logic [7:0] loc_addr,
   input wire logic [7:0] loc_wdata,
   input wire logic loc_rvalid_r,
   input wire logic rem_wr,
   input wire logic rem_rd,
   input wire logic rem_ack_r,
   input wire logic link_up,
   input wire logic two_lane,
   input wire logic remote_interrupt_in_n,
   input wire logic [3:0] local_int_evt,
   input wire logic interrupt_out_n,
   input wire logic remote_interrupt_mirror,
   input wire logic [3:0] fwd_gpio_p1_r,
   input wire logic [3:0] d_gpio_oe_r,
   input wire logic [3:0] rgpio_out_r,
   input wire logic [3:0] rgpio_oe_r,
   input wire logic [3:0] i2s_data_r
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire loc_any = loc_wr | loc_rd;
   wire any_acc = loc_any | rem_wr | rem_rd;
   a_rd_answer: assert property (ce && loc_rd |=> loc_rvalid_r)
      else $error("local read not answered");
   a_rem_ack: assert property (ce && (rem_rd || rem_wr) && !loc_any |=> rem_ack_r)
      else $error("remote access not answered");
   a_rem_refuse: assert property (ce && loc_any |=> !rem_ack_r)
      else $error("remote access served beside local");
   a_int_hold: assert property (!interrupt_out_n && !(ce && any_acc)
      |=> !interrupt_out_n)
      else $error("interrupt released without a read");
   a_int_clear: assert property (ce && loc_rd && !loc_wr && loc_addr == 8'hC7
      && local_int_evt == 4'h0 && remote_interrupt_in_n
      && $past(remote_interrupt_in_n) && $past(remote_interrupt_in_n, 2)
      && $past(remote_interrupt_in_n, 3) |=> interrupt_out_n)
      else $error("status read did not release interrupt");
   a_mirror_down: assert property (ce && !link_up |=> remote_interrupt_mirror)
      else $error("mirror low without link");
   a_mirror_follow: assert property ((ce && link_up && !remote_interrupt_in_n)[*4]
      |-> !remote_interrupt_mirror)
      else $error("mirror does not follow input");
   a_rgpio_drive: assert property (ce && loc_wr && !loc_rd && loc_addr == 8'h10
      && loc_wdata[3:0] == 4'h9 ##1 ce
      |=> rgpio_oe_r[0] && rgpio_out_r[0])
      else $error("register pin not driven high");
   a_i2s_over: assert property (rgpio_oe_r[0] && $past(rgpio_oe_r[0])
      |-> !i2s_data_r[0])
      else $error("audio input not overridden");
   a_lane_off: assert property ((!two_lane)[*3]
      |-> fwd_gpio_p1_r == 4'h0 && d_gpio_oe_r == 4'h0)
      else $error("second port active in one-lane mode");
endmodule // lig_link_int_gpio_chk
bind lig_link_int_gpio lig_link_int_gpio_chk u_lig_link_int_gpio_chk (
   .sys_clk, .rst, .ce, .loc_wr, .loc_rd, .loc_addr, .loc_wdata,
   .loc_rvalid_r, .rem_wr, .rem_rd, .rem_ack_r, .link_up, .two_lane,
   .remote_interrupt_in_n, .local_int_evt, .interrupt_out_n,
   .remote_interrupt_mirror, .fwd_gpio_p1_r, .d_gpio_oe_r, .rgpio_out_r,
   .rgpio_oe_r, .i2s_data_r
);
`default_nettype wire

// ### tb/lig_des_model.sv
/* Behavioural remote deserializer: interrupt line and port0 back channel.
   Assumes the bench calls its tasks and supplies sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module lig_des_model (
   input wire logic sys_clk,
   output logic remote_interrupt_in_n,
   output logic [2:0] backchannel_gpio_rate_mode,
   output logic bc_frame_start,
   output logic bc_valid_p0,
   output logic [3:0] bc_gpio_p0
);
   initial begin
      remote_interrupt_in_n = 1'h1;
      backchannel_gpio_rate_mode = 3'h0;
      bc_frame_start = 1'h0;
      bc_valid_p0 = 1'h0;
      bc_gpio_p0 = 4'h0;
   end
   task automatic set_int(input logic lvl);
      @(posedge sys_clk);
      #1 remote_interrupt_in_n = lvl;
   endtask
   // Sends n samples of v then one surplus sample of ~v, with gap idle
   // cycles between samples; idle data is inverted so it never looks held.
   task automatic send_frame(input logic [2:0] m, input int n,
      input logic [3:0] v, input int gap);
      @(posedge sys_clk);
      #1 backchannel_gpio_rate_mode = m;
      for (int i = 0; i <= n; i++) begin
         @(posedge sys_clk);
         #1 bc_frame_start = (i == 0);
         bc_valid_p0 = 1'h1;
         bc_gpio_p0 = (i < n) ? v : ~v;
         repeat (gap) begin
            @(posedge sys_clk);
            #1 bc_frame_start = 1'h0;
            bc_valid_p0 = 1'h0;
            bc_gpio_p0 = ~bc_gpio_p0;
         end
      end
      @(posedge sys_clk);
      #1 bc_frame_start = 1'h0;
      bc_valid_p0 = 1'h0;
      bc_gpio_p0 = ~bc_gpio_p0;
   endtask
endmodule // lig_des_model
`default_nettype wire

// ### tb/tb_lig_link_int_gpio.sv
/* Self-checking bench for the link interrupt and GPIO block.
   Assumes lig_des_model stands in for the remote deserializer. */
`timescale 1ns/1ps
`default_nettype none
module tb_lig_link_int_gpio;
   logic sys_clk, rst = 1'h1, loc_wr = 1'h0, loc_rd = 1'h0;
   logic rem_wr = 1'h0, rem_rd = 1'h0, link_up = 1'h1, two_lane = 1'h1;
   logic ce = 1'h1;
   logic [3:0] local_int_evt = 4'h0, d_gpio_out_r, d_gpio_oe_r;
   logic [7:0] loc_addr = 8'h00, loc_wdata = 8'h00, q;
   logic [7:0] rem_addr = 8'h00, rem_wdata = 8'h00, loc_rdata_r, rem_rdata_r;
   logic loc_rvalid_r, rem_ack_r, interrupt_out_n, remote_interrupt_mirror;
   logic remote_interrupt_in_n, bc_frame_start, bc_valid_p0;
   logic [2:0] backchannel_gpio_rate_mode;
   logic [3:0] bc_gpio_p0, fwd_gpio_p0_r, fwd_gpio_p1_r, gpio_out_r, gpio_oe_r;
   logic [3:0] gpio_in = 4'h0, d_gpio_in = 4'h0, rgpio_in = 4'h0;
   logic [3:0] rgpio_out_r, rgpio_oe_r, i2s_data_r;
   int error_cnt = 0, tests_run = 0, cyc = 0;
   lig_link_int_gpio u_lig_link_int_gpio (
      .sys_clk, .rst, .ce, .loc_wr, .loc_rd, .loc_addr, .loc_wdata,
      .loc_rdata_r, .loc_rvalid_r, .rem_wr, .rem_rd, .rem_addr, .rem_wdata,
      .rem_rdata_r, .rem_ack_r, .link_up, .two_lane, .remote_interrupt_in_n,
      .local_int_evt, .interrupt_out_n, .remote_interrupt_mirror,
      .backchannel_gpio_rate_mode, .bc_frame_start, .bc_valid_p0, .bc_gpio_p0,
      .bc_valid_p1(1'h0), .bc_gpio_p1(4'h0), .fwd_gpio_p0_r, .fwd_gpio_p1_r,
      .gpio_in, .gpio_out_r, .gpio_oe_r, .d_gpio_in, .d_gpio_out_r,
      .d_gpio_oe_r, .rgpio_in, .rgpio_out_r, .rgpio_oe_r, .i2s_data_r);
   lig_des_model u_lig_des_model (.sys_clk, .remote_interrupt_in_n,
      .backchannel_gpio_rate_mode, .bc_frame_start, .bc_valid_p0, .bc_gpio_p0);
   initial begin
      sys_clk = 1'h0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         final_report();
      end
   end
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] s, e);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic acc(input logic r, w, input logic [7:0] a, d);
      tick(1);
      {loc_wr, loc_rd, rem_wr, rem_rd} = {!r && w, !r && !w, r && w, r && !w};
      {loc_addr, rem_addr, loc_wdata, rem_wdata} = {a, a, d, d};
      tick(1);
      {loc_wr, loc_rd, rem_wr, rem_rd} = 4'h0;
      q = r ? rem_rdata_r : loc_rdata_r;
      if (r || !w)
         chk("answer", {7'h0, r ? rem_ack_r : loc_rvalid_r}, 8'h01);
   endtask
   task automatic wr(input logic [7:0] a, d);
      acc(1'h0, 1'h1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, e);
      acc(1'h0, 1'h0, a, 8'h00);
      chk("read data", q, e);
   endtask
   task automatic t_reset;
      chk("int_out", {7'h0, interrupt_out_n}, 8'h01);
      rd(8'h0D, 8'h00);
      rd(8'h1E, 8'h01);
      rd(8'h55, 8'h00);
      rd(8'hC7, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_int;
      wr(8'hC6, 8'h21);
      u_lig_des_model.set_int(1'h0);
      tick(6);
      chk("int_out", {7'h0, interrupt_out_n}, 8'h00);
      chk("mirror", {7'h0, remote_interrupt_mirror}, 8'h00);
      rd(8'hC7, 8'h21);
      chk("int_out", {7'h0, interrupt_out_n}, 8'h01);
      tick(6);
      chk("int_out", {7'h0, interrupt_out_n}, 8'h01);
      u_lig_des_model.set_int(1'h1);
      tick(6);
      chk("mirror", {7'h0, remote_interrupt_mirror}, 8'h01);
      u_lig_des_model.set_int(1'h0);
      tick(6);
      chk("int_out", {7'h0, interrupt_out_n}, 8'h00);
      link_up = 1'h0;
      tick(3);
      chk("mirror", {7'h0, remote_interrupt_mirror}, 8'h01);
      link_up = 1'h1;
      u_lig_des_model.set_int(1'h1);
      tick(6);
      rd(8'hC7, 8'h21);
      chk("int_out", {7'h0, interrupt_out_n}, 8'h01);
      wr(8'hC6, 8'h03);
      local_int_evt = 4'h1;
      tick(1);
      local_int_evt = 4'h0;
      tick(1);
      chk("int_out", {7'h0, interrupt_out_n}, 8'h00);
      rd(8'hC7, 8'h03);
      chk("int_out", {7'h0, interrupt_out_n}, 8'h01);
      $display("interrupt test done");
   endtask
   task automatic t_fwd;
      wr(8'h1E, 8'h03);
      wr(8'h0D, 8'h03);
      wr(8'h0E, 8'h33);
      wr(8'h0F, 8'h03);
      gpio_in = 4'hA;
      d_gpio_in = 4'h5;
      tick(4);
      chk("fwd p0", {4'h0, fwd_gpio_p0_r}, 8'h0A);
      chk("fwd p1", {4'h0, fwd_gpio_p1_r}, 8'h05);
      wr(8'h1E, 8'h02);
      wr(8'h0D, 8'h05);
      wr(8'h1E, 8'h01);
      rd(8'h0D, 8'h03);
      wr(8'h1E, 8'h03);
      rd(8'h0D, 8'h05);
      chk("d oe", {4'h0, d_gpio_oe_r}, 8'h01);
      chk("d out", {4'h0, d_gpio_out_r}, 8'h00);
      two_lane = 1'h0;
      tick(4);
      chk("fwd p1", {4'h0, fwd_gpio_p1_r}, 8'h00);
      chk("d oe", {4'h0, d_gpio_oe_r}, 8'h00);
      $display("forward test done");
   endtask
   task automatic t_bc;
      logic [3:0] e;
      logic [2:0] m [4] = '{3'h0, 3'h3, 3'h2, 3'h1};
      int n [4] = '{1, 6, 10, 15};
      logic [3:0] k [4] = '{4'hF, 4'hF, 4'h3, 4'h1};
      e = 4'h0;
      wr(8'h1E, 8'h01);
      wr(8'h0D, 8'h05);
      wr(8'h0E, 8'h55);
      wr(8'h0F, 8'h05);
      for (int i = 0; i < 4; i++) begin
         e = e ^ k[i];
         u_lig_des_model.send_frame(m[i], n[i], e, i);
         tick(3);
         chk("bc out", {4'h0, gpio_out_r}, {4'h0, e});
      end
      chk("bc oe", {4'h0, gpio_oe_r}, 8'h0F);
      $display("back channel test done");
   endtask
   task automatic t_rgpio;
      ce = 1'h0;
      rgpio_in = 4'hF;
      tick(4);
      chk("i2s frozen", {4'h0, i2s_data_r}, 8'h00);
      ce = 1'h1;
      tick(4);
      chk("i2s", {4'h0, i2s_data_r}, 8'h0F);
      wr(8'h10, 8'h19);
      tick(1);
      chk("rg oe", {4'h0, rgpio_oe_r}, 8'h03);
      chk("rg out", {4'h0, rgpio_out_r}, 8'h01);
      acc(1'h1, 1'h1, 8'h11, 8'h33);
      rgpio_in = 4'hC;
      tick(4);
      chk("i2s", {4'h0, i2s_data_r}, 8'h00);
      rd(8'h1D, 8'h0C);
      acc(1'h1, 1'h0, 8'h11, 8'h00);
      chk("rem data", q, 8'h33);
      $display("register gpio test done");
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      #1 rst = 1'h0;
      t_reset();
      t_int();
      t_fwd();
      t_bc();
      t_rgpio();
      final_report();
   end
endmodule // tb_lig_link_int_gpio
`default_nettype wire
